// ### verilog/itl_pkg.sv
// package: constants, entry layout and helpers for the isdn link slave port
package itl_pkg;

	localparam int NLINK  = 2;
	localparam int NCTL   = 4;
	localparam int NENT   = 32;
	localparam int ENT_W  = 5;
	localparam int IDX_W  = 6;
	localparam int BIT_W  = 8;
	localparam int AW     = 9;
	localparam int DW     = 16;
	localparam int SYNC_W = 5;

	// basic-rate frame figures
	localparam int BASIC_FRAME_BITS  = 20;
	localparam int FRAME_KBPS        = 160;
	localparam int BEARER_KBPS       = 64;
	localparam int DCH_KBPS          = 16;
	localparam int SYNC_TO_DATA_BITS = 1;

	// synchroniser lanes per link
	localparam int S_RCLK  = 0;
	localparam int S_RSYNC = 1;
	localparam int S_RXD   = 2;
	localparam int S_TCLK  = 3;
	localparam int S_TSYNC = 4;

	// register map
	localparam logic [AW-1:0] RX_TAB_BASE = 9'h000;
	localparam logic [AW-1:0] TX_TAB_BASE = 9'h080;
	localparam logic [AW-1:0] MODE_ADDR   = 9'h100;
	localparam logic [AW-1:0] CROUTE_ADDR = 9'h101;
	localparam logic [AW-1:0] STAT_A_ADDR = 9'h102;
	localparam logic [AW-1:0] STAT_B_ADDR = 9'h103;
	localparam logic [AW-1:0] FLEN_ADDR   = 9'h104;

	// route entry layout
	localparam int LST_BIT  = 0;
	localparam int BYT_BIT  = 1;
	localparam int CNT_LSB  = 2;
	localparam int CNT_W    = 4;
	localparam int CSEL_LSB = 6;
	localparam int CSEL_W   = 3;
	localparam int SSEL_LSB = 9;
	localparam int SSEL_W   = 4;
	localparam logic [DW-1:0] ENTRY_UNUSED = 16'h0001;

	// serial_iface_mode_reg and clock_route_reg fields
	localparam int GM_LSB  = 0;
	localparam int CRT_LSB = 2;
	localparam int EN_LSB  = 4;
	localparam int GRS_LSB = 0;
	localparam int MAP_LSB = 4;
	localparam logic [DW-1:0] MODE_RESET   = 16'h0000;
	localparam logic [DW-1:0] CROUTE_RESET = 16'h0000;

	typedef logic [DW-1:0] itl_entry_t;

	function automatic logic [CSEL_W-1:0] itl_csel(input itl_entry_t w);
		return w[CSEL_LSB +: CSEL_W];
	endfunction

	function automatic logic [SSEL_W-1:0] itl_ssel(input itl_entry_t w);
		return w[SSEL_LSB +: SSEL_W];
	endfunction

	// bits covered by one entry: count+1 bits, or count+1 bytes
	function automatic logic [BIT_W-1:0] itl_len(input itl_entry_t w);
		logic [CNT_W:0] n;
		n = {1'b0, w[CNT_LSB +: CNT_W]} + 5'h01;
		return w[BYT_BIT] ? {n, 3'h0} : {3'h0, n};
	endfunction

	function automatic logic itl_in_tab(input logic [AW-1:0] a, input logic [AW-1:0] base);
		return a[AW-1:IDX_W] == base[AW-1:IDX_W];
	endfunction

endpackage

// ### verilog/itl_sync2.sv
// two-flop synchroniser for pin inputs from the link side
`timescale 1ns/1ps
module itl_sync2
#(
	parameter int W = 1
)(
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else
		begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule

// ### verilog/itl_slot_walker.sv
// frame position tracker: walks route entries bit by bit on the link clock
`timescale 1ns/1ps
module itl_slot_walker
	import itl_pkg::*;
#(
	parameter bit TX_SIDE = 1'b0
)(
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic             enable,
	input  wire logic             clk_s,
	input  wire logic             sync_s,
	input  wire itl_entry_t       entry_word,
	output logic                  bit_edge,
	output logic                  step,
	output logic                  frame_start,
	output logic      [ENT_W-1:0] ent
);
	logic             clk_d_ff;
	logic             armed_ff;
	logic             active_ff;
	logic [ENT_W-1:0] ent_ff;
	logic [BIT_W-1:0] bit_ff;
	logic             fall;
	logic             rise;
	logic [ENT_W-1:0] cur_ent;
	logic [BIT_W-1:0] cur_bit;

	assign fall        = clk_d_ff & ~clk_s;
	assign rise        = ~clk_d_ff & clk_s;
	// sync caught on falling edge; tx changes on rising, rx samples on falling
	assign frame_start = enable & fall & sync_s;
	assign bit_edge    = enable & (TX_SIDE ? rise : fall);
	assign step        = bit_edge & (armed_ff | active_ff) & ~frame_start;
	// armed means first data bit is the one after the sync bit
	assign cur_ent     = armed_ff ? '0 : ent_ff;
	assign cur_bit     = armed_ff ? '0 : bit_ff;
	assign ent         = cur_ent;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			clk_d_ff <= 1'b0;
		else
			clk_d_ff <= clk_s;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			armed_ff  <= 1'b0;
			active_ff <= 1'b0;
			ent_ff    <= '0;
			bit_ff    <= '0;
		end
		else if (!enable)
		begin
			armed_ff  <= 1'b0;
			active_ff <= 1'b0;
			ent_ff    <= '0;
			bit_ff    <= '0;
		end
		else if (frame_start)
		begin
			armed_ff  <= 1'b1;
			active_ff <= 1'b0;
		end
		else if (step)
		begin
			armed_ff <= 1'b0;
			if (cur_bit + 8'h01 == itl_len(entry_word))
			begin
				bit_ff <= '0;
				// last-entry flag ends the frame until the next sync
				if (entry_word[LST_BIT] || cur_ent == ENT_W'(NENT - 1))
				begin
					active_ff <= 1'b0;
					ent_ff    <= '0;
				end
				else
				begin
					active_ff <= 1'b1;
					ent_ff    <= cur_ent + 5'h01;
				end
			end
			else
			begin
				active_ff <= 1'b1;
				bit_ff    <= cur_bit + 8'h01;
				ent_ff    <= cur_ent;
			end
		end
	end
endmodule

// ### verilog/itl_link_port.sv
// top of the isdn link slave port: route tables, routing, d-channel grant
`timescale 1ns/1ps
module itl_link_port
	import itl_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire logic [AW-1:0]     reg_addr,
	input  wire logic [DW-1:0]     reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DW-1:0]     reg_rdata,
	input  wire logic [NLINK-1:0]  link_rx_bit_clock,
	input  wire logic [NLINK-1:0]  link_rx_frame_pulse,
	input  wire logic [NLINK-1:0]  link_rx_line,
	input  wire logic [NLINK-1:0]  link_tx_bit_clock,
	input  wire logic [NLINK-1:0]  tx_frame_pulse_pin,
	output logic      [NLINK-1:0]  link_tx_line,
	output logic      [NLINK-1:0]  link_tx_line_oe,
	output logic      [NLINK-1:0]  dchan_request_out,
	output logic      [4*NLINK-1:0] link_strobe_out,
	output logic      [NCTL-1:0]   ser_rx_bit,
	output logic      [NCTL-1:0]   ser_rx_valid,
	input  wire logic [NCTL-1:0]   ser_tx_bit,
	output logic      [NCTL-1:0]   ser_tx_take,
	input  wire logic [NCTL-1:0]   ser_dch_pending,
	input  wire logic [NCTL-1:0]   ser_early_buf,
	output logic      [NCTL-1:0]   ser_grant,
	output logic      [NCTL-1:0]   ser_abort
);
	////////////////////////////////////////////////////////////////////////////
	itl_entry_t        rx_tab_ff [2**IDX_W];
	itl_entry_t        tx_tab_ff [2**IDX_W];
	logic [DW-1:0]     mode_ff;
	logic [DW-1:0]     croute_ff;
	logic [DW-1:0]     rdata_ff;
	logic [DW-1:0]     nxt_rdata;
	logic [SYNC_W-1:0] pin_s [NLINK];
	logic [NLINK-1:0]  rx_step, rx_fs, tx_step, tx_edge;
	logic [ENT_W-1:0]  rx_ent [NLINK];
	logic [ENT_W-1:0]  tx_ent [NLINK];
	itl_entry_t        rx_word [NLINK];
	itl_entry_t        tx_word [NLINK];
	logic [NLINK-1:0]  gm, crt, en;
	logic [NCTL-1:0]   gsel, map;
	logic [NLINK-1:0]  gnt_ff, req_ff, nxt_req, gnt_fell;
	logic [NLINK-1:0]  tx_line_ff, tx_oe_ff, tx_hit, tx_bit;
	logic [3:0]        strobe_ff [NLINK];
	logic [BIT_W-1:0]  fcnt_ff [NLINK];
	logic [BIT_W-1:0]  flen_ff [NLINK];
	logic [NCTL-1:0]   rx_bit_ff, rx_valid_ff, nxt_rx_bit, nxt_rx_valid;
	logic [NCTL-1:0]   allow, take, grant_ff, abort_ff;

	assign gm   = mode_ff[GM_LSB +: NLINK];
	assign crt  = mode_ff[CRT_LSB +: NLINK];
	assign en   = mode_ff[EN_LSB +: NLINK];
	assign gsel = croute_ff[GRS_LSB +: NCTL];
	assign map  = croute_ff[MAP_LSB +: NCTL];

	////////////////////////////////////////////////////////////////////////////
	// one timing pair per link, each on its own master clock
	for (genvar i = 0; i < NLINK; i++)
	begin : g_link
		logic tclk_sel;
		logic tsync_sel;

		itl_sync2 #(.W(SYNC_W)) u_sync (
			.core_clk (core_clk),
			.resetn   (resetn),
			.async_in ({tx_frame_pulse_pin[i], link_tx_bit_clock[i], link_rx_line[i],
			            link_rx_frame_pulse[i], link_rx_bit_clock[i]}),
			.sync_out (pin_s[i])
		);

		// shared timing when both directions face the same link
		assign tclk_sel  = crt[i] ? pin_s[i][S_RCLK] : pin_s[i][S_TCLK];
		assign tsync_sel = crt[i] ? pin_s[i][S_RSYNC] : pin_s[i][S_TSYNC];

		itl_slot_walker #(.TX_SIDE(1'b0)) u_rx (
			.core_clk    (core_clk),
			.resetn      (resetn),
			.enable      (en[i]),
			.clk_s       (pin_s[i][S_RCLK]),
			.sync_s      (pin_s[i][S_RSYNC]),
			.entry_word  (rx_word[i]),
			.bit_edge    (),
			.step        (rx_step[i]),
			.frame_start (rx_fs[i]),
			.ent         (rx_ent[i])
		);

		itl_slot_walker #(.TX_SIDE(1'b1)) u_tx (
			.core_clk    (core_clk),
			.resetn      (resetn),
			.enable      (en[i]),
			.clk_s       (tclk_sel),
			.sync_s      (tsync_sel),
			.entry_word  (tx_word[i]),
			.bit_edge    (tx_edge[i]),
			.step        (tx_step[i]),
			.frame_start (),
			.ent         (tx_ent[i])
		);

		assign rx_word[i] = rx_tab_ff[{1'(i), rx_ent[i]}];
		assign tx_word[i] = tx_tab_ff[{1'(i), tx_ent[i]}];
		assign gnt_fell[i] = rx_fs[i] & gnt_ff[i] & ~pin_s[i][S_TSYNC];
		assign link_strobe_out[4*i +: 4] = strobe_ff[i];
	end

	////////////////////////////////////////////////////////////////////////////
	// register port; tables reset to the unused pattern
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int k = 0; k < 2**IDX_W; k++)
			begin
				rx_tab_ff[k] <= ENTRY_UNUSED;
				tx_tab_ff[k] <= ENTRY_UNUSED;
			end
		end
		else if (reg_wr && itl_in_tab(reg_addr, RX_TAB_BASE))
			rx_tab_ff[reg_addr[IDX_W-1:0]] <= reg_wdata;
		else if (reg_wr && itl_in_tab(reg_addr, TX_TAB_BASE))
			tx_tab_ff[reg_addr[IDX_W-1:0]] <= reg_wdata;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_ff   <= MODE_RESET;
			croute_ff <= CROUTE_RESET;
		end
		else if (reg_wr && reg_addr == MODE_ADDR)
			mode_ff <= reg_wdata;
		else if (reg_wr && reg_addr == CROUTE_ADDR)
			croute_ff <= reg_wdata;
	end

	always_comb
	begin
		nxt_rdata = '0;
		if (itl_in_tab(reg_addr, RX_TAB_BASE))
			nxt_rdata = rx_tab_ff[reg_addr[IDX_W-1:0]];
		else if (itl_in_tab(reg_addr, TX_TAB_BASE))
			nxt_rdata = tx_tab_ff[reg_addr[IDX_W-1:0]];
		else
		begin
			case (reg_addr)
				MODE_ADDR:   nxt_rdata = mode_ff;
				CROUTE_ADDR: nxt_rdata = croute_ff;
				STAT_A_ADDR: nxt_rdata = {4'h0, req_ff[0], gnt_ff[0], tx_ent[0], rx_ent[0]};
				STAT_B_ADDR: nxt_rdata = {4'h0, req_ff[1], gnt_ff[1], tx_ent[1], rx_ent[1]};
				FLEN_ADDR:   nxt_rdata = {flen_ff[1], flen_ff[0]};
				default:     nxt_rdata = '0;
			endcase
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rdata_ff <= '0;
		else
			rdata_ff <= reg_rd ? nxt_rdata : '0;
	end
	assign reg_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////////////
	// receive routing: unrouted bits never reach a controller
	always_comb
	begin
		nxt_rx_valid = '0;
		nxt_rx_bit   = rx_bit_ff;
		for (int c = 0; c < NCTL; c++)
			for (int i = 0; i < NLINK; i++)
				if (rx_step[i] && itl_csel(rx_word[i]) == 3'(c + 1) && map[c] == 1'(i))
				begin
					nxt_rx_valid[c] = 1'b1;
					nxt_rx_bit[c]   = pin_s[i][S_RXD];
				end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rx_bit_ff   <= '0;
			rx_valid_ff <= '0;
		end
		else
		begin
			rx_bit_ff   <= nxt_rx_bit;
			rx_valid_ff <= nxt_rx_valid;
		end
	end
	assign ser_rx_bit   = rx_bit_ff;
	assign ser_rx_valid = rx_valid_ff;

	// strobes follow the select field of the entry in progress
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			for (int i = 0; i < NLINK; i++)
				strobe_ff[i] <= '0;
		else
			for (int i = 0; i < NLINK; i++)
				if (rx_fs[i] || !en[i])
					strobe_ff[i] <= '0;
				else if (rx_step[i])
					strobe_ff[i] <= itl_ssel(rx_word[i]);
	end

	// bits per frame, to check the basic-rate layout from software
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			for (int i = 0; i < NLINK; i++)
			begin
				fcnt_ff[i] <= '0;
				flen_ff[i] <= '0;
			end
		else
			for (int i = 0; i < NLINK; i++)
				if (rx_fs[i])
				begin
					fcnt_ff[i] <= '0;
					flen_ff[i] <= fcnt_ff[i];
				end
				else if (rx_step[i])
					fcnt_ff[i] <= fcnt_ff[i] + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit routing; a contended controller sends only while granted
	always_comb
	begin
		take   = '0;
		tx_hit = '0;
		tx_bit = '1;
		for (int c = 0; c < NCTL; c++)
		begin
			allow[c] = ~gsel[c] | ~gm[map[c]] | gnt_ff[map[c]];
			for (int i = 0; i < NLINK; i++)
				if (itl_csel(tx_word[i]) == 3'(c + 1) && map[c] == 1'(i) && allow[c])
				begin
					tx_hit[i] = 1'b1;
					tx_bit[i] = ser_tx_bit[c];
					take[c]   = take[c] | tx_step[i];
				end
		end
	end
	assign ser_tx_take = take;

	// released at every bit edge that is not a routed bit
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tx_line_ff <= '1;
			tx_oe_ff   <= '0;
		end
		else
			for (int i = 0; i < NLINK; i++)
				if (tx_edge[i] || !en[i])
				begin
					tx_oe_ff[i]   <= tx_step[i] & tx_hit[i];
					tx_line_ff[i] <= tx_step[i] & tx_hit[i] ? tx_bit[i] : 1'b1;
				end
	end
	assign link_tx_line    = tx_line_ff;
	assign link_tx_line_oe = tx_oe_ff;

	////////////////////////////////////////////////////////////////////////////
	// d-channel contention; grant lives on the tx sync pin
	always_comb
	begin
		nxt_req = '0;
		for (int c = 0; c < NCTL; c++)
			if (ser_dch_pending[c] && gsel[c])
				nxt_req[map[c]] = 1'b1;
		nxt_req = nxt_req & gm;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			req_ff <= '0;
			gnt_ff <= '0;
		end
		else
		begin
			req_ff <= nxt_req;
			for (int i = 0; i < NLINK; i++)
				if (rx_fs[i])
					gnt_ff[i] <= pin_s[i][S_TSYNC];
		end
	end
	assign dchan_request_out = req_ff;

	// abort restarts the frame only while it is in its first two buffers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			grant_ff <= '0;
			abort_ff <= '0;
		end
		else
			for (int c = 0; c < NCTL; c++)
			begin
				grant_ff[c] <= gsel[c] & allow[c];
				abort_ff[c] <= gsel[c] & gm[map[c]] & gnt_fell[map[c]]
				               & ser_dch_pending[c] & ser_early_buf[c];
			end
	end
	assign ser_grant = grant_ff;
	assign ser_abort = abort_ff;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	tx_drive_gate_a: assert property ($rose(link_tx_line_oe[0]) |-> $past(tx_step[0]))
		else $error("tx line enabled outside a routed bit");
	rx_capture_a: assert property (ser_rx_valid[0] |-> $past(|rx_step))
		else $error("rx bit delivered without a frame bit step");
	grant_sample_a: assert property ($changed(gnt_ff[0]) |-> $past(rx_fs[0]))
		else $error("grant changed away from frame sync");
	frame_restart_a: assert property (rx_fs[0] |=> rx_ent[0] == '0)
		else $error("frame did not restart at entry zero");
	req_rise_a: assert property ($rose(dchan_request_out[0]) |-> $past(|(ser_dch_pending & gsel)))
		else $error("request raised with nothing pending");
	req_drop_a: assert property ((!(|(ser_dch_pending & gsel))) [*2] |-> !dchan_request_out[0])
		else $error("request held with nothing pending");
	dch_hold_a: assert property ((ser_tx_take[0] && gsel[0] && gm[map[0]]) |-> gnt_ff[map[0]])
		else $error("contended controller sent without grant");
	abort_cause_a: assert property (ser_abort[0] |-> $past(ser_early_buf[0] && gnt_fell[map[0]]))
		else $error("abort without grant loss in early buffers");
	grant_fwd_a: assert property (ser_grant[0] |-> $past(gsel[0]))
		else $error("grant forwarded to unselected controller");
	strobe_follow_a: assert property (rx_step[0] |=> strobe_ff[0] == $past(itl_ssel(rx_word[0])))
		else $error("strobe does not follow entry select");

	tx_bit_c: cover property (tx_step[0] && tx_hit[0]);
	abort_c: cover property (ser_abort[0]);
	basic_frame_c: cover property (rx_fs[0] && fcnt_ff[0] == 8'(BASIC_FRAME_BITS));
	merged_c: cover property (ser_rx_valid[0] ##[1:100] ser_rx_valid[0]);
endmodule

// ### sim/itl_phy_master.sv
// link master model: gated bit clock, frame pulse, rx data and grant pin
`timescale 1ns/1ps
module itl_phy_master
#(
	parameter int BITS = 20
)(
	input  wire logic            go,
	input  wire logic [BITS-1:0] frame_bits,
	input  wire logic            grant_lvl,
	output logic                 bit_clk,
	output logic                 frame_pulse,
	output logic                 rx_line,
	output logic                 grant_pin,
	output logic                 busy
);
	initial
	begin
		bit_clk     = 1'b0;
		frame_pulse = 1'b0;
		rx_line     = 1'b1;
		grant_pin   = 1'b0;
		busy        = 1'b0;
	end
	// clock stands still between frames; grant held for the whole frame
	always @(posedge go)
	begin
		busy        = 1'b1;
		grant_pin   = grant_lvl;
		frame_pulse = 1'b1;
		#160 bit_clk = 1'b1;
		#160 bit_clk = 1'b0;
		for (int i = 0; i < BITS; i++)
		begin
			#160 bit_clk = 1'b1;
			frame_pulse = 1'b0;
			rx_line = frame_bits[BITS-1-i];
			#160 bit_clk = 1'b0;
		end
		// no pull on the line: show the opposite of the last bit once released
		#160 rx_line = ~rx_line;
		busy = 1'b0;
	end
endmodule

// ### sim/testbench.sv
// self-checking bench for the isdn link slave port
`timescale 1ns/1ps
module testbench;
	import itl_pkg::*;
	logic               core_clk;
	logic               resetn;
	logic [AW-1:0]      reg_addr;
	logic [DW-1:0]      reg_wdata;
	logic               reg_wr;
	logic               reg_rd;
	logic [DW-1:0]      reg_rdata;
	logic [NLINK-1:0]   rclk, rsync, rline, gpin, busy, tx_line, tx_oe, req;
	logic [4*NLINK-1:0] strobe;
	logic [NCTL-1:0]    rx_bit, rx_valid, tx_take, grant, abort_p, tx_bit, pending, early;
	logic               go;
	logic               grant_lvl;
	logic [19:0]        pattern;
	logic [DW-1:0]      rd;
	int                 n_errors, checks_done, n_abort, oe_rises, oe_b, strobe_a, strobe_b;
	logic               oe_prev;
	int                 tx_ones, tx_zeros;
	logic               take_prev;
	logic [15:0]        rxw [NCTL];
	int                 rxn [NCTL];
	int                 txn [NCTL];
	// mixed byte and bit entries; the last one also raises strobe 0
	logic [15:0]        route [5] = '{16'h0082, 16'h0040, 16'h0000, 16'h0102, 16'h0241};
	int                 nbit [NCTL] = '{2, 8, 0, 8};

	itl_link_port i_dut (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.link_rx_bit_clock(rclk), .link_rx_frame_pulse(rsync), .link_rx_line(rline),
		.link_tx_bit_clock(rclk), .tx_frame_pulse_pin(gpin), .link_tx_line(tx_line),
		.link_tx_line_oe(tx_oe), .dchan_request_out(req), .link_strobe_out(strobe),
		.ser_rx_bit(rx_bit), .ser_rx_valid(rx_valid), .ser_tx_bit(tx_bit),
		.ser_tx_take(tx_take), .ser_dch_pending(pending), .ser_early_buf(early),
		.ser_grant(grant), .ser_abort(abort_p));
	itl_phy_master i_phy_a (.go(go), .frame_bits(pattern), .grant_lvl(grant_lvl),
		.bit_clk(rclk[0]), .frame_pulse(rsync[0]), .rx_line(rline[0]), .grant_pin(gpin[0]),
		.busy(busy[0]));
	itl_phy_master i_phy_b (.go(go), .frame_bits(~pattern), .grant_lvl(grant_lvl),
		.bit_clk(rclk[1]), .frame_pulse(rsync[1]), .rx_line(rline[1]), .grant_pin(gpin[1]),
		.busy(busy[1]));

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk)
	begin
		for (int c = 0; c < NCTL; c++)
		begin
			if (rx_valid[c] === 1'b1)
			begin
				rxw[c] = {rxw[c][14:0], rx_bit[c]};
				rxn[c]++;
			end
			if (tx_take[c] === 1'b1)
				txn[c]++;
		end
		if (abort_p[0] === 1'b1)
			n_abort++;
		if (tx_oe[0] === 1'b1 && oe_prev !== 1'b1)
			oe_rises++;
		oe_prev = tx_oe[0];
		// line and enable show the taken bit in the cycle after the take
		if (take_prev === 1'b1 && tx_oe[0] === 1'b1)
		begin
			if (tx_line[0] === 1'b1)
				tx_ones++;
			else if (tx_line[0] === 1'b0)
				tx_zeros++;
		end
		take_prev = |tx_take;
		if (tx_oe[1] !== 1'b0)
			oe_b++;
		if (strobe[0] === 1'b1)
			strobe_a++;
		if (strobe[7:4] !== 4'h0)
			strobe_b++;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic reg_write(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge core_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [AW-1:0] a, output logic [DW-1:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		// data stand for one cycle only: take them at the edge that closes it
		@(posedge core_clk);
		d = reg_rdata;
	endtask

	// bits of one controller in line order, owners as laid out in the route table
	function automatic logic [15:0] exp_rx(input int c, input logic [19:0] p);
		logic [15:0] w;
		int          o;
		w = 16'h0000;
		for (int i = 0; i < 20; i++)
		begin
			o = (i < 8) ? 1 : (i == 8 || i == 18) ? 0 : (i >= 10 && i <= 17) ? 3 : -1;
			if (o == c)
				w = {w[14:0], p[19-i]};
		end
		return w;
	endfunction

	task automatic run_frame();
		@(negedge core_clk);
		for (int c = 0; c < NCTL; c++)
		begin
			rxw[c] = 16'h0000;
			rxn[c] = 0;
			txn[c] = 0;
		end
		n_abort = 0;
		oe_rises = 0;
		oe_b = 0;
		strobe_a = 0;
		strobe_b = 0;
		tx_ones = 0;
		tx_zeros = 0;
		@(posedge core_clk);
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 3000 && busy !== 2'b00; i++)
			@(posedge core_clk);
		if (busy !== 2'b00)
		begin
			n_errors++;
			results();
		end
		// link inputs pass a two-flop synchroniser before the last bit lands
		repeat (8) @(posedge core_clk);
	endtask

	initial
	begin
		resetn = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tx_bit = 4'h9;
		pending = 4'h0;
		early = 4'h1;
		go = 1'b0;
		grant_lvl = 1'b0;
		pattern = 20'h5A3C9;
		n_errors = 0;
		checks_done = 0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		#1 check("oe after reset", 16'(tx_oe), 16'h0000);
		check("request after reset", 16'(req), 16'h0000);
		reg_read(MODE_ADDR, rd);
		check("mode reset", rd, MODE_RESET);
		reg_read(CROUTE_ADDR, rd);
		check("clock route reset", rd, CROUTE_RESET);
		reg_read(RX_TAB_BASE + 9'h005, rd);
		check("unused entry", rd, ENTRY_UNUSED);
		reg_write(9'h1FF, 16'hFFFF);
		reg_read(9'h1FF, rd);
		check("unmapped", rd, 16'h0000);
		$display("test reset done");
		// both links' tables: layout in link a only, every other entry (all of link b) set to the unused pattern
		for (int i = 0; i < 2 * NENT; i++)
		begin
			rd = (i < 5) ? route[i % 5] : ENTRY_UNUSED;
			reg_write(RX_TAB_BASE + 9'(i), rd);
			reg_write(TX_TAB_BASE + 9'(i), rd);
		end
		reg_read(TX_TAB_BASE + 9'h004, rd);
		check("tx entry", rd, route[4]);
		reg_write(MODE_ADDR, 16'h003F);
		reg_write(CROUTE_ADDR, 16'h0001);
		reg_read(MODE_ADDR, rd);
		check("mode", rd, 16'h003F);
		pending <= 4'h1;
		repeat (4) @(posedge core_clk);
		check("request up", 16'(req), 16'h0001);
		$display("test setup done");
		// odd frames lose the grant; only the first loss is still in the early buffers
		for (int f = 0; f < 4; f++)
		begin
			grant_lvl <= (f % 2 == 0);
			early <= (f < 2) ? 4'h1 : 4'h0;
			pattern <= pattern ^ 20'hC3A56;
			run_frame();
			for (int c = 0; c < NCTL; c++)
			begin
				check("rx word", rxw[c], exp_rx(c, pattern));
				check("rx count", 16'(rxn[c]), 16'(nbit[c]));
				check("tx takes", 16'(txn[c]), 16'((c == 0 && f % 2) ? 0 : nbit[c]));
			end
			check("grant", 16'(grant), (f % 2 == 0) ? 16'h0001 : 16'h0000);
			check("abort", 16'(n_abort), 16'(f == 1));
			check("tx ones", 16'(tx_ones), (f % 2 == 0) ? 16'h000A : 16'h0008);
			check("tx zeros", 16'(tx_zeros), 16'h0008);
			check("oe bursts", 16'(oe_rises), 16'h0002);
			check("link b oe", 16'(oe_b), 16'h0000);
			check("strobe a", 16'(strobe_a > 0), 16'h0001);
			check("strobe b", 16'(strobe_b), 16'h0000);
			$display("test frame %0d done", f);
		end
		// link a layout spans 19 positions, the 20th idle; link b stops after its first unused entry
		reg_read(FLEN_ADDR, rd);
		check("frame length", rd, 16'h0113);
		reg_read(STAT_A_ADDR, rd);
		check("status a", rd, 16'h0800);
		pending <= 4'h0;
		repeat (4) @(posedge core_clk);
		check("request down", 16'(req), 16'h0000);
		$display("test request done");
		results();
	end
endmodule
